// >>> design/tccc_map.svh
/*
 Register map, field positions and reset values of the timer
 capture/compare control block.
 Assumes it is included by bare name from the top module and the bench.
*/
`ifndef TCCC_MAP_SVH
`define TCCC_MAP_SVH
// Register indices; byte address is four times the index
`define TCCC_IDX_COUNT 6'h24
`define TCCC_IDX_SYSCTL 6'h26
`define TCCC_IDX_TOGGLE 6'h27
`define TCCC_IDX_ACTION 6'h28
`define TCCC_IDX_EDGE 6'h29
`define TCCC_IDX_STATUS 6'h30
`define TCCC_IDX_MASK 6'h31
// Field positions
`define TCCC_BIT_TIMER_ON 7
`define TCCC_BIT_FAST_CLR 4
`define TCCC_BIT_WRAP 7
// Reset values
`define TCCC_RST_COUNT 16'h0000
`define TCCC_RST_BYTE 8'h00
`define TCCC_COUNT_MAX 16'hffff
`endif

// >>> design/tccc_pkg.sv
/*
 Types shared by the timer capture/compare control block.
 Assumes nothing beyond the register map header.
*/
package tccc_pkg;
    // Pin action on compare, mode bit above level bit
    typedef enum logic [1:0] {
        TCCC_ACT_OFF = 2'b00,
        TCCC_ACT_TOGGLE = 2'b01,
        TCCC_ACT_LOW = 2'b10,
        TCCC_ACT_HIGH = 2'b11
    } tccc_act_t;
    // Capture edge choice, high select bit above low
    typedef enum logic [1:0] {
        TCCC_EDGE_NONE = 2'b00,
        TCCC_EDGE_RISE = 2'b01,
        TCCC_EDGE_FALL = 2'b10,
        TCCC_EDGE_ANY = 2'b11
    } tccc_edge_t;
endpackage : tccc_pkg

// >>> design/tccc_top.sv
/*
 Control part of a four channel 16-bit timer: counter, enable, fast flag
 clearing, overflow toggle, compare pin actions and capture edge select,
 with a classic Wishbone register slave and one level interrupt.
 Assumes a prescaler tick, compare match and force pulses and fast-clear
 access pulses from timer logic on the same clock; capture pins are async.
*/
// Register access over Wishbone was left to the implementer.
`include "tccc_map.svh"

module tccc_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Timer context
    input wire logic special_mode,
    input wire logic timer_tick,
    input wire logic [3:0] chan_is_compare,
    input wire logic [3:0] ch3_compare_mask,
    input wire logic [3:0] compare_match,
    input wire logic [3:0] force_compare,
    input wire logic [3:0] capture_read,
    input wire logic [3:0] compare_write,
    // Capture pins, asynchronous
    input wire logic [3:0] timer_channel_pin,
    // Results to the timer
    output logic [15:0] main_count,
    output logic [3:0] capture_strobe,
    output logic [3:0] compare_output_line,
    output logic [3:0] compare_output_oe,
    output logic [3:0] channel_event_flag,
    output logic wrap_flag,
    output logic irq
);
    import tccc_pkg::*;

    // Control registers
    logic timer_on; // Counter runs while set
    logic fast_flag_clear; // Access side-effect clearing
    logic [3:0] overflow_toggle_enable; // Per channel wrap toggle
    logic [7:0] output_pin_action; // Mode/level pairs
    logic [7:0] capture_edge_select; // Edge pairs
    logic [7:0] irq_mask; // Same layout as status

    // Bus decode
    logic acc; // Request taken this cycle
    logic wr; // Write taken this cycle
    logic [5:0] idx; // Word index
    logic [7:0] st_reg; // Status layout view
    logic [31:0] rd_data; // Read mux

    // Counter step signals
    logic cnt_wr; // Counter write accepted
    logic step; // Counter advances
    logic wrap; // Counter wraps this cycle

    // Capture synchroniser, edge history
    logic [3:0] pin_s1; // First stage, read by pin_s2 only
    logic [3:0] pin_s2; // Synchronised level
    logic [3:0] pin_s3; // Previous level

    // Event decode
    logic [3:0] cap_hit; // Capture edge seen
    logic [3:0] cmp_hit; // Real compare event
    logic [3:0] set_flag; // Flag set this cycle

    // Edge match for one channel
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic now);
        tccc_edge_t e;
        e = tccc_edge_t'(sel);
        case (e)
            TCCC_EDGE_RISE: edge_hit = !prev && now;
            TCCC_EDGE_FALL: edge_hit = prev && !now;
            TCCC_EDGE_ANY: edge_hit = prev != now;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // Pin level after a compare action
    function automatic logic pin_after(input logic [1:0] pair, input logic cur);
        tccc_act_t a;
        a = tccc_act_t'(pair);
        case (a)
            TCCC_ACT_TOGGLE: pin_after = !cur;
            TCCC_ACT_LOW: pin_after = 1'b0;
            TCCC_ACT_HIGH: pin_after = 1'b1;
            default: pin_after = cur;
        endcase
    endfunction : pin_after

    // Request decode; one access per ack
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = acc && wb_we_i;
    assign idx = wb_adr_i[7:2];

    // Counter loads only in special mode, low 16 bits
    assign cnt_wr = wr && idx == `TCCC_IDX_COUNT && special_mode;
    assign step = timer_on && timer_tick && !cnt_wr;
    assign wrap = step && main_count == `TCCC_COUNT_MAX;

    // Status view: channel flags low, wrap flag high
    always_comb begin
        st_reg = {wrap_flag, 3'h0, channel_event_flag};
    end

    // Read mux; unmapped words read zero
    always_comb begin
        rd_data = 32'h0;
        case (idx)
            `TCCC_IDX_COUNT: rd_data = {16'h0, main_count};
            `TCCC_IDX_SYSCTL: rd_data = {24'h0, timer_on, 2'h0, fast_flag_clear, 4'h0};
            `TCCC_IDX_TOGGLE: rd_data = {28'h0, overflow_toggle_enable};
            `TCCC_IDX_ACTION: rd_data = {24'h0, output_pin_action};
            `TCCC_IDX_EDGE: rd_data = {24'h0, capture_edge_select};
            `TCCC_IDX_STATUS: rd_data = {24'h0, st_reg};
            `TCCC_IDX_MASK: rd_data = {24'h0, irq_mask};
            default: rd_data = 32'h0;
        endcase
    end

    // Bus answer: ack one cycle after the request, data registered
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= acc;
            if (acc) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // Control register writes, lane 0 carries the byte registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer_on <= 1'b0;
            fast_flag_clear <= 1'b0;
            overflow_toggle_enable <= 4'h0;
            output_pin_action <= `TCCC_RST_BYTE;
            capture_edge_select <= `TCCC_RST_BYTE;
            irq_mask <= `TCCC_RST_BYTE;
        end else if (wr && wb_sel_i[0]) begin
            case (idx)
                `TCCC_IDX_SYSCTL: begin
                    timer_on <= wb_dat_i[`TCCC_BIT_TIMER_ON];
                    fast_flag_clear <= wb_dat_i[`TCCC_BIT_FAST_CLR];
                end
                `TCCC_IDX_TOGGLE: overflow_toggle_enable <= wb_dat_i[3:0];
                `TCCC_IDX_ACTION: output_pin_action <= wb_dat_i[7:0];
                `TCCC_IDX_EDGE: capture_edge_select <= wb_dat_i[7:0];
                `TCCC_IDX_MASK: irq_mask <= {wb_dat_i[7], 3'h0, wb_dat_i[3:0]};
                default: ;
            endcase
        end
    end

    // Counter; a write loads at once, not aligned to the tick
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_count <= `TCCC_RST_COUNT;
        end else if (cnt_wr) begin
            // Byte lanes let software split the word, at its own risk
            if (wb_sel_i[0]) main_count[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) main_count[15:8] <= wb_dat_i[15:8];
        end else if (step) begin
            main_count <= main_count + 16'h1;
        end
    end

    // Two-flop synchroniser plus history for edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_s3 <= 4'h0;
        end else begin
            pin_s1 <= timer_channel_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Event decode per channel
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cap_hit[i] = !chan_is_compare[i] &&
                edge_hit(capture_edge_select[2*i+1 -: 2], pin_s3[i], pin_s2[i]);
            // Forced compares never raise the flag
            cmp_hit[i] = chan_is_compare[i] && compare_match[i] && !force_compare[i];
        end
        set_flag = cap_hit | cmp_hit;
    end

    // Capture strobe to the capture registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            capture_strobe <= 4'h0;
        end else begin
            capture_strobe <= cap_hit;
        end
    end

    // Channel flags; a set in the clearing cycle wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            channel_event_flag <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (set_flag[i]) begin
                    channel_event_flag[i] <= 1'b1;
                end else if (wr && wb_sel_i[0] && idx == `TCCC_IDX_STATUS && wb_dat_i[i]) begin
                    channel_event_flag[i] <= 1'b0;
                end else if (fast_flag_clear && (capture_read[i] || compare_write[i])) begin
                    channel_event_flag[i] <= 1'b0;
                end
            end
        end
    end

    // Wrap flag; any counter access clears it under fast clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrap_flag <= 1'b0;
        end else if (wrap) begin
            wrap_flag <= 1'b1;
        end else if (wr && wb_sel_i[0] && idx == `TCCC_IDX_STATUS && wb_dat_i[`TCCC_BIT_WRAP]) begin
            wrap_flag <= 1'b0;
        end else if (fast_flag_clear && acc && idx == `TCCC_IDX_COUNT) begin
            wrap_flag <= 1'b0;
        end
    end

    // Compare pin levels; wrap toggle first, then mask, then force or match alike
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            compare_output_line <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!chan_is_compare[i]) begin
                    // Capture channels leave the line alone
                end else if (wrap && overflow_toggle_enable[i]) begin
                    compare_output_line[i] <= !compare_output_line[i];
                end else if (ch3_compare_mask[i]) begin
                    // Masked channels take their data elsewhere
                end else if (force_compare[i] || compare_match[i]) begin
                    compare_output_line[i] <= pin_after(output_pin_action[2*i+1 -: 2],
                        compare_output_line[i]);
                end
            end
        end
    end

    // Drive enable from the stored pairs
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            compare_output_oe[i] = chan_is_compare[i] && |output_pin_action[2*i+1 -: 2];
        end
    end

    // Interrupt, level while any unmasked status bit is set
    assign irq = |(st_reg & irq_mask);

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_count_step: assert property (step && !wrap |=> main_count == $past(main_count) + 16'h1)
        else $error("Counter did not advance");
    a_count_idle: assert property (!timer_on && !cnt_wr |=> $stable(main_count))
        else $error("Counter moved while stopped");
    a_normal_wr: assert property (wr && idx == `TCCC_IDX_COUNT && !special_mode && !step
        |=> $stable(main_count))
        else $error("Counter written outside special mode");
    a_wrap_flag: assert property ($past(main_count) == 16'hffff && main_count == 16'h0000
        && !$past(cnt_wr) |-> wrap_flag)
        else $error("Wrap did not set flag");
    a_fast_wrap: assert property (fast_flag_clear && acc && idx == `TCCC_IDX_COUNT && !wrap
        |=> !wrap_flag)
        else $error("Counter access kept wrap flag");
    a_fast_chan: assert property (fast_flag_clear && capture_read[0] && !set_flag[0]
        |=> !channel_event_flag[0])
        else $error("Fast clear missed channel flag");
    a_set_wins: assert property (set_flag[1] |=> channel_event_flag[1] [*1])
        else $error("Channel event lost");
    a_wrap_tog: assert property (wrap && overflow_toggle_enable[2] && chan_is_compare[2]
        |=> compare_output_line[2] != $past(compare_output_line[2]))
        else $error("Overflow toggle missing");
    a_oe_pair: assert property (wr && wb_sel_i[0] && idx == `TCCC_IDX_ACTION && wb_dat_i[7:6] != 2'b00
        ##1 chan_is_compare[3] |-> compare_output_oe[3])
        else $error("Pin not driven after action write");
endmodule : tccc_top

// >>> sim/test_timer_capture_compare_ctrl.sv
/*
 Self-checking bench for the timer capture/compare control block.
 Assumes the design package and top module are compiled before it.
*/
`include "tccc_map.svh"

module test_timer_capture_compare_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import tccc_pkg::*;
    // Byte addresses of the registers
    localparam logic [7:0] a_cnt = {`TCCC_IDX_COUNT, 2'b00};
    localparam logic [7:0] a_sys = {`TCCC_IDX_SYSCTL, 2'b00};
    localparam logic [7:0] a_tog = {`TCCC_IDX_TOGGLE, 2'b00};
    localparam logic [7:0] a_act = {`TCCC_IDX_ACTION, 2'b00};
    localparam logic [7:0] a_edg = {`TCCC_IDX_EDGE, 2'b00};
    localparam logic [7:0] a_sts = {`TCCC_IDX_STATUS, 2'b00};
    localparam logic [7:0] a_msk = {`TCCC_IDX_MASK, 2'b00};
    // Stimulus, all valued at time zero
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic spec = 1'b0;
    logic tick = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [3:0] cmp = 4'h0;
    logic [3:0] msk = 4'h0;
    logic [3:0] mat = 4'h0;
    logic [3:0] frc = 4'h0;
    logic [3:0] crd = 4'h0;
    logic [3:0] cwr = 4'h0;
    logic [3:0] pin = 4'h0;
    // Observed outputs
    logic [31:0] rdat;
    logic ack;
    logic [15:0] cnt;
    logic [3:0] cstb;
    logic [3:0] line;
    logic [3:0] oe;
    logic [3:0] flag;
    logic wrap;
    logic irq;
    // Bookkeeping
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int nstb = 0;
    int seed = 32'hf8cb;
    logic [31:0] expq[$];
    logic [3:0] exp_line = 4'h0;

    tccc_top u_dut (
        .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .special_mode(spec), .timer_tick(tick), .chan_is_compare(cmp), .ch3_compare_mask(msk),
        .compare_match(mat), .force_compare(frc), .capture_read(crd), .compare_write(cwr),
        .timer_channel_pin(pin), .main_count(cnt), .capture_strobe(cstb),
        .compare_output_line(line), .compare_output_oe(oe), .channel_event_flag(flag),
        .wrap_flag(wrap), .irq(irq)
    );

    // 50 MHz clock
    always #10 mclk = ~mclk;

    // Hang guard; the whole run needs well under this
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    // Capture strobes counted over all channels
    always @(posedge mclk) begin
        nstb <= nstb + $countones(cstb);
    end

    // Read answers checked against the oldest note
    always @(posedge mclk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (expq.size() == 0) begin
                chk("rd_extra", 32'h1, rdat);
            end else begin
                chk("rd_data", expq.pop_front(), rdat);
            end
        end
    end

    // One comparison, counted
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // Holds the request until ack is sampled, then releases it
    task automatic wait_ack;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        we <= 1'b0;
        // Registered ack: sampled high on the second edge of the request
        chk("ack_wait", 32'h2, 32'(n));
    endtask : wait_ack

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h3);
        @(posedge mclk);
        cyc <= 1'b1;
        we <= 1'b1;
        adr <= a;
        dat <= d;
        sel <= s;
        wait_ack();
    endtask : wr

    // Notes the expected word, then reads
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        @(posedge mclk);
        cyc <= 1'b1;
        adr <= a;
        sel <= 4'hf;
        wait_ack();
    endtask : rd

    // One-cycle event pulses, then one edge for the result to land
    task automatic pulse(input logic [3:0] m, input logic [3:0] f, input logic [3:0] r,
                         input logic [3:0] w, input logic t);
        @(posedge mclk);
        mat <= m;
        frc <= f;
        crd <= r;
        cwr <= w;
        tick <= t;
        @(posedge mclk);
        mat <= 4'h0;
        frc <= 4'h0;
        crd <= 4'h0;
        cwr <= 4'h0;
        tick <= 1'b0;
        @(posedge mclk);
    endtask : pulse

    task automatic results;
        if (expq.size() != 0) begin
            mismatches++;
        end
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    initial begin
        logic [7:0] v;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        // Reset values, an unmapped place among them
        rd(a_cnt, 32'h0);
        rd(a_sys, 32'h0);
        rd(a_act, 32'h0);
        rd(a_edg, 32'h0);
        wr(8'hfc, 32'hff);
        rd(8'hfc, 32'h0);
        // Random bytes round-trip; a write without lane 0 is ignored
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            wr(i[0] ? a_edg : a_act, {24'h0, v});
            rd(i[0] ? a_edg : a_act, {24'h0, v});
        end
        wr(a_act, 32'h0);
        wr(a_act, 32'h55, 4'h2);
        rd(a_act, 32'h0);
        wr(a_sys, 32'hff);
        rd(a_sys, 32'h90);
        // Counter writes need special mode; no count while off
        wr(a_sys, 32'h0);
        wr(a_cnt, 32'h1234);
        rd(a_cnt, 32'h0);
        spec <= 1'b1;
        wr(a_cnt, 32'hfffe);
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 1'b1);
        rd(a_cnt, 32'hfffe);
        wr(a_sys, 32'h80);
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 1'b1);
        rd(a_cnt, 32'hffff);
        chk("count", 32'hffff, {16'h0, cnt});
        chk("wrap", 32'h0, {31'h0, wrap});
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 1'b1);
        chk("wrap", 32'h1, {31'h0, wrap});
        rd(a_cnt, 32'h0);
        rd(a_sts, 32'h80);
        // Interrupt raised, masked and cleared
        chk("irq", 32'h0, {31'h0, irq});
        wr(a_msk, 32'h80);
        chk("irq", 32'h1, {31'h0, irq});
        wr(a_sts, 32'h00);
        chk("irq", 32'h1, {31'h0, irq});
        wr(a_sts, 32'h80);
        chk("irq", 32'h0, {30'h0, wrap, irq});
        // Fast clear: a counter read drops the wrap flag
        wr(a_sys, 32'h90);
        wr(a_cnt, 32'hffff);
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 1'b1);
        chk("wrap", 32'h1, {31'h0, wrap});
        rd(a_cnt, 32'h0);
        chk("wrap", 32'h0, {31'h0, wrap});
        // Every pin action on every channel, pair position per channel
        cmp <= 4'hf;
        for (int n = 0; n < 4; n++) begin
            for (int a = 3; a >= 0; a--) begin
                wr(a_act, 32'(a) << (2 * n));
                chk("oe", 32'(a != 0) << n, {28'h0, oe});
                pulse(4'h1 << n, 4'h0, 4'h0, 4'h0, 1'b0);
                if (a == int'(TCCC_ACT_TOGGLE)) begin
                    exp_line[n] = ~exp_line[n];
                end else if (a != int'(TCCC_ACT_OFF)) begin
                    exp_line[n] = a[0];
                end
                chk("line", {28'h0, exp_line}, {28'h0, line});
            end
        end
        // Flags: force sets none, zero write keeps, one clears, compare write clears
        chk("flag", 32'hf, {28'h0, flag});
        wr(a_sts, 32'h0f);
        pulse(4'h6, 4'h1, 4'h0, 4'h0, 1'b0);
        chk("flag", 32'h6, {28'h0, flag});
        wr(a_sts, 32'h00);
        wr(a_sts, 32'h02);
        chk("flag", 32'h4, {28'h0, flag});
        pulse(4'h0, 4'h0, 4'h0, 4'h4, 1'b0);
        chk("flag", 32'h0, {28'h0, flag});
        // Masked channel keeps its pin
        msk <= 4'h1;
        wr(a_act, 32'h2);
        pulse(4'h1, 4'h0, 4'h0, 4'h0, 1'b0);
        chk("line", 32'hf, {28'h0, line});
        msk <= 4'h0;
        // Wrap toggle beats a force; a capture channel does not toggle
        cmp <= 4'hd;
        wr(a_act, 32'h3);
        wr(a_tog, 32'h03);
        wr(a_cnt, 32'hffff);
        pulse(4'h0, 4'h1, 4'h0, 4'h0, 1'b1);
        chk("line", 32'he, {28'h0, line});
        wr(a_tog, 32'h0);
        // Every edge choice on every channel
        cmp <= 4'h0;
        for (int n = 0; n < 4; n++) begin
            for (int e = 0; e < 4; e++) begin
                int base;
                wr(a_edg, 32'(e) << (2 * n));
                base = nstb;
                pin[n] <= 1'b1;
                repeat (6) @(posedge mclk);
                pin[n] <= 1'b0;
                repeat (6) @(posedge mclk);
                chk("captures", (e == 0) ? 0 : (e == 3) ? 2 : 1, 32'(nstb - base));
            end
        end
        chk("flag", 32'hf, {28'h0, flag});
        pulse(4'h0, 4'h0, 4'h1, 4'h0, 1'b0);
        chk("flag", 32'he, {28'h0, flag});
        results();
    end
endmodule : test_timer_capture_compare_ctrl
